// ### logic/vpa_arbiter.sv
// vc0 port schedule table, load sequencer and slot walker
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module vpa_arbiter (
  input  wire logic                     clk,         // core clock
  input  wire logic                     sys_rst,     // async reset
  input  wire vpa_pkg::vpa_bus_req_type bus,         // register access
  output logic [31:0]                   rd_data,     // read data
  input  wire logic                     arb_advance, // period ended
  output vpa_pkg::vpa_grant_type        grant,       // current grant
  output logic                          load_pending // table not latched
);

  localparam int NS = vpa_pkg::NUM_SLOTS;

  logic [31:0]                 shd_q [3];
  logic [95:0]                 act_q;
  logic [4:0]                  last_q;
  vpa_pkg::vpa_load_state_type st_q;
  logic [1:0]                  cnt_q;
  logic                        pend_q;
  logic                        dirty_q;
  logic [31:0]                 rd_q;
  logic [4:0]                  ptr_q;
  vpa_pkg::vpa_grant_type      grant_q;
  logic                        first_q;

  logic                        tbl_wr;
  logic [1:0]                  tbl_idx;
  logic                        ctrl_wr;
  logic                        load_req;
  logic [NS-1:0]               dec_ok;
  logic [3:0]                  dec_port [NS];
  logic [NS-1:0]               slot_ok;
  logic                        restart;
  logic [4:0]                  start;
  logic                        found;
  logic [4:0]                  hit;
  logic [31:0]                 rd_d;

  // write decode for the three table words
  always_comb begin
    tbl_wr  = 1'b0;
    tbl_idx = 2'd0;
    if (bus.wr && bus.addr == vpa_pkg::OFS_WORD0) begin
      tbl_wr  = 1'b1; // RULE2
      tbl_idx = 2'd0;
    end else if (bus.wr && bus.addr == vpa_pkg::OFS_WORD1) begin
      tbl_wr  = 1'b1;
      tbl_idx = 2'd1;
    end else if (bus.wr && bus.addr == vpa_pkg::OFS_WORD2) begin
      tbl_wr  = 1'b1;
      tbl_idx = 2'd2;
    end
  end

  assign ctrl_wr  = bus.wr && (bus.addr == vpa_pkg::OFS_CTRL);
  assign load_req = ctrl_wr && bus.wdata[vpa_pkg::LOAD_BIT]; // RULE13

  // software view of the schedule
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shd_q[0] <= vpa_pkg::WORD0_RST; // RULE9
      shd_q[1] <= vpa_pkg::WORD1_RST; // RULE10
      shd_q[2] <= vpa_pkg::WORD2_RST; // RULE11
    end else if (tbl_wr) begin
      shd_q[tbl_idx] <= bus.wdata; // RULE1
    end
  end

  // last slot of the scheme, clamped to the table
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_q <= vpa_pkg::LAST_RST;
    end else if (ctrl_wr) begin
      if (bus.wdata[4:0] > vpa_pkg::LAST_RST) begin
        last_q <= vpa_pkg::LAST_RST;
      end else begin
        last_q <= bus.wdata[4:0];
      end
    end
  end

  // copy sequencer, one word per cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q  <= vpa_pkg::LD_IDLE;
      cnt_q <= 2'd0;
    end else begin
      case (st_q)
        vpa_pkg::LD_IDLE: begin
          if (load_req) begin
            st_q  <= vpa_pkg::LD_COPY; // RULE13
            cnt_q <= 2'd0;
          end
        end
        vpa_pkg::LD_COPY: begin
          if (cnt_q == 2'd2) begin
            st_q <= vpa_pkg::LD_DONE;
          end
          cnt_q <= cnt_q + 2'd1;
        end
        vpa_pkg::LD_DONE: begin
          st_q <= vpa_pkg::LD_IDLE;
        end
        default: begin
          st_q <= vpa_pkg::LD_IDLE;
        end
      endcase
    end
  end

  // table used by the arbiter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_q <= {vpa_pkg::WORD2_RST, vpa_pkg::WORD1_RST,
                vpa_pkg::WORD0_RST}; // RULE9 RULE10 RULE11
    end else if (st_q == vpa_pkg::LD_COPY) begin
      act_q[32*cnt_q +: 32] <= shd_q[cnt_q]; // RULE13
    end
  end

  // writes seen while a copy runs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dirty_q <= 1'b0;
    end else if (st_q == vpa_pkg::LD_IDLE) begin
      dirty_q <= 1'b0;
    end else if (tbl_wr) begin
      dirty_q <= 1'b1;
    end
  end

  // pending flag, a write beats the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (tbl_wr) begin
      pend_q <= 1'b1; // RULE12
    end else if (st_q == vpa_pkg::LD_DONE && !dirty_q) begin
      pend_q <= 1'b0; // RULE12
    end
  end

  assign load_pending = pend_q;

  // read multiplexer
  always_comb begin
    rd_d = 32'h0000_0000;
    if (bus.addr == vpa_pkg::OFS_WORD0) begin
      rd_d = shd_q[0];
    end else if (bus.addr == vpa_pkg::OFS_WORD1) begin
      rd_d = shd_q[1];
    end else if (bus.addr == vpa_pkg::OFS_WORD2) begin
      rd_d = shd_q[2];
    end else if (bus.addr == vpa_pkg::OFS_CTRL) begin
      rd_d[4:0] = last_q; // load bit reads zero, RULE13
    end else if (bus.addr == vpa_pkg::OFS_STAT) begin
      rd_d[vpa_pkg::PEND_BIT] = pend_q;
    end
  end

  // read data stands one cycle only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 32'h0000_0000;
    end else if (bus.rd) begin
      rd_q <= rd_d;
    end else begin
      rd_q <= 32'h0000_0000;
    end
  end

  assign rd_data = rd_q;

  // per-slot code decode
  for (genvar i = 0; i < NS; i++) begin : g_dec
    vpa_slot_decode u_dec (
      .code  (act_q[4*i +: 4]),
      .valid (dec_ok[i]),
      .port  (dec_port[i])
    );
    assign slot_ok[i] = dec_ok[i] && (5'(i) <= last_q); // RULE3
  end

  assign restart = (st_q == vpa_pkg::LD_DONE);

  // first slot to visit
  always_comb begin
    if (restart || ptr_q >= last_q) begin
      start = 5'd0; // RULE14
    end else begin
      start = ptr_q + 5'd1; // RULE14
    end
  end

  // search ahead for the next usable slot
  always_comb begin
    logic [4:0] idx;
    idx   = start;
    found = 1'b0;
    hit   = 5'd0;
    for (int k = 0; k < NS; k++) begin
      if (!found && slot_ok[idx]) begin
        found = 1'b1; // RULE3
        hit   = idx;
      end
      if (idx >= last_q) begin
        idx = 5'd0;
      end else begin
        idx = idx + 5'd1;
      end
    end
  end

  // grant register and slot pointer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q         <= 5'd0;
      grant_q.valid <= 1'b1;
      grant_q.port  <= 4'h0; // RULE5
    end else if (restart || arb_advance) begin
      ptr_q         <= hit; // RULE14
      grant_q.valid <= found; // RULE3
      grant_q.port  <= dec_port[hit];
    end
  end

  assign grant = grant_q;

  // marks the first cycle after reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // defaults are in place after reset
  chk_reset_defaults: assert property ( // RULE9 RULE10 RULE11
    @(posedge clk) disable iff (sys_rst)
    first_q |-> (shd_q[0] == 32'h3322_1100 &&
                 shd_q[1] == 32'h7766_5544 &&
                 shd_q[2] == 32'hBBAA_9988))
    else $error("schedule defaults wrong after reset");

  // word written then read back intact
  chk_word_readback: assert property ( // RULE1 RULE2
    @(posedge clk) disable iff (sys_rst)
    (bus.wr && bus.addr == vpa_pkg::OFS_WORD1) ##1 !bus.wr ##1
    (bus.rd && bus.addr == vpa_pkg::OFS_WORD1)
    |=> rd_data == $past(bus.wdata, 3))
    else $error("table word did not read back");

  // load bit never reads as one
  chk_load_reads_zero: assert property ( // RULE13
    @(posedge clk) disable iff (sys_rst)
    (bus.rd && bus.addr == 12'h220) |=> !rd_data[16])
    else $error("load bit read as one");

  // table write raises pending
  chk_pend_on_write: assert property ( // RULE12
    @(posedge clk) disable iff (sys_rst)
    tbl_wr |=> load_pending)
    else $error("pending not set by table write");

  // pending drops only as a copy finishes
  chk_pend_held: assert property ( // RULE12
    @(posedge clk) disable iff (sys_rst)
    $fell(load_pending) |-> $past(st_q) == vpa_pkg::LD_DONE)
    else $error("pending cleared outside a load");

  // a load request finishes in bounded time
  chk_load_bound: assert property ( // RULE13
    @(posedge clk) disable iff (sys_rst)
    (load_req && st_q == vpa_pkg::LD_IDLE)
    |=> st_q == vpa_pkg::LD_COPY [*3] ##1 st_q == vpa_pkg::LD_DONE)
    else $error("table copy did not finish in four cycles");

  // an advance never idles while a slot is usable
  chk_no_idle: assert property ( // RULE3
    @(posedge clk) disable iff (sys_rst)
    (arb_advance && |slot_ok && st_q != vpa_pkg::LD_COPY)
    |=> grant.valid)
    else $error("usable slot left an idle period");

  // granted port equals the slot code
  chk_code_map: assert property ( // RULE5 RULE6 RULE7
    @(posedge clk) disable iff (sys_rst)
    (grant.valid && !first_q && $changed(ptr_q))
    |-> grant.port == act_q[4*ptr_q +: 4])
    else $error("grant port differs from slot code");

  // reserved codes are never granted
  chk_no_reserved: assert property ( // RULE8 RULE3
    @(posedge clk) disable iff (sys_rst)
    grant.valid |-> grant.port <= 4'hB)
    else $error("reserved code granted");

  // pointer steps up by one to a usable neighbour
  chk_step_order: assert property ( // RULE14
    @(posedge clk) disable iff (sys_rst)
    (arb_advance && !restart && ptr_q < last_q &&
     slot_ok[ptr_q + 5'd1]) |=> ptr_q == $past(ptr_q) + 5'd1)
    else $error("pointer did not step in order");

  // pointer wraps after the last slot
  chk_wrap_zero: assert property ( // RULE14
    @(posedge clk) disable iff (sys_rst)
    (arb_advance && !restart && ptr_q == last_q && slot_ok[0])
    |=> ptr_q == 5'd0)
    else $error("pointer did not wrap to slot zero");

  // no usable slot leaves the grant invalid
  chk_none_usable: assert property ( // RULE3 RULE8
    @(posedge clk) disable iff (sys_rst)
    ((restart || arb_advance) && !(|slot_ok)) |=> !grant.valid)
    else $error("grant valid with no usable slot");

  // a write during the copy keeps pending up
  chk_pend_kept: assert property ( // RULE12
    @(posedge clk) disable iff (sys_rst)
    (st_q == vpa_pkg::LD_DONE && dirty_q) |=> load_pending)
    else $error("pending cleared despite a write during copy");

  // an oversized last slot is clamped to the table
  chk_last_clamped: assert property ( // RULE14
    @(posedge clk) disable iff (sys_rst)
    (ctrl_wr && bus.wdata[4:0] > vpa_pkg::LAST_RST)
    |=> last_q == vpa_pkg::LAST_RST)
    else $error("last slot not clamped");

  // a finished load restarts the walk at slot zero
  chk_restart_zero: assert property ( // RULE14
    @(posedge clk) disable iff (sys_rst)
    (restart && slot_ok[0]) |=> ptr_q == 5'd0)
    else $error("load did not restart at slot zero");

  // read data stands for one cycle only
  chk_rd_one_cycle: assert property ( // RULE2
    @(posedge clk) disable iff (sys_rst)
    !bus.rd |=> rd_data == 32'h0000_0000)
    else $error("read data outlived its cycle");

endmodule

// ### logic/vpa_pkg.sv
// constants, types and behaviour notes for the vc0 port schedule table
// Notes on behaviour
// RULE1: eight 4-bit slots per word, slot0 lowest
// RULE2: slots 0..23 in words at 0x230..0x238
// RULE3: invalid slot skipped with no lost period
// RULE4: software never programs reserved or egress code
// RULE5: code zero grants upstream port 0
// RULE6: codes one to nine grant same port
// RULE7: codes ten and eleven grant ports 10, 11
// RULE8: codes twelve to fifteen are reserved, no grant
// RULE9: reset slots 0..7 to ports 0..3 pairwise
// RULE10: reset slots 8..15 to ports 4..7 pairwise
// RULE11: reset slots 16..23 to ports 8..11 pairwise
// RULE12: pending sets on table write, clears after load
// RULE13: load bit write-one starts copy, reads zero
// RULE14: slots visited ascending, wrap after last slot
package vpa_pkg;

  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int SLOT_W    = 4;
  localparam int NUM_SLOTS = 24;
  localparam int NUM_WORDS = 3;
  localparam int PTR_W     = 5;

  // register byte addresses
  localparam logic [11:0] OFS_CTRL   = 12'h220;
  localparam logic [11:0] OFS_STAT   = 12'h224;
  localparam logic [11:0] OFS_WORD0  = 12'h230;
  localparam logic [11:0] OFS_WORD1  = 12'h234;
  localparam logic [11:0] OFS_WORD2  = 12'h238;

  // control and status fields
  localparam int LAST_LSB   = 0;
  localparam int LAST_W     = 5;
  localparam int LOAD_BIT   = 16;
  localparam int PEND_BIT   = 16;
  localparam logic [4:0] LAST_RST = 5'h17;

  // highest code that names a port
  localparam logic [3:0] MAX_PORT = 4'hB;

  // default schedule, two slots per port
  localparam logic [31:0] WORD0_RST = 32'h3322_1100;
  localparam logic [31:0] WORD1_RST = 32'h7766_5544;
  localparam logic [31:0] WORD2_RST = 32'hBBAA_9988;

  // table copy sequencer
  typedef enum logic [2:0] {
    LD_IDLE = 3'b001,
    LD_COPY = 3'b010,
    LD_DONE = 3'b100
  } vpa_load_state_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vpa_bus_req_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] port;
  } vpa_grant_type;

endpackage

// ### logic/vpa_slot_decode.sv
// decodes one schedule slot code into a port grant
`timescale 1ns/1ps
module vpa_slot_decode (
  input  wire logic [3:0] code,   // slot contents
  output logic            valid,  // names a real port
  output logic [3:0]      port    // port number
);

  // codes equal the port number, above eleven reserved
  assign valid = (code <= vpa_pkg::MAX_PORT); // RULE8
  assign port  = code; // RULE5 RULE6 RULE7

endmodule

// ### test/vpa_port_model.sv
// ingress request side model: ends arbitration periods on demand
`timescale 1ns/1ps
module vpa_port_model (
  input  wire logic clk,         // core clock
  input  wire logic sys_rst,     // async reset
  input  wire logic period_end,  // bench asks to close the period
  input  wire logic hold_off,    // slow mode, delay the pulse by one cycle
  output logic      arb_advance  // one-cycle period-over pulse
);
  logic pend_q;

  // registered pulse, optionally delayed one cycle in slow mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arb_advance <= 1'b0;
      pend_q      <= 1'b0;
    end else begin
      arb_advance <= (period_end & ~hold_off) | pend_q;
      pend_q      <= period_end & hold_off;
    end
  end
endmodule

// ### test/testbench.sv
// self-checking bench for the vc0 port schedule table
`timescale 1ns/1ps
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, g, e); \
  end \
end
module testbench;
  logic                     clk;
  logic                     sys_rst;
  vpa_pkg::vpa_bus_req_type bus;
  logic [31:0]              rd_data;
  logic                     arb_advance;
  vpa_pkg::vpa_grant_type   grant;
  logic                     load_pending;
  logic                     period_end;
  logic                     hold_off;
  logic [31:0]              v;
  int                       err_count;
  int                       n_checks;

  vpa_arbiter u_dut (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .bus          (bus),
    .rd_data      (rd_data),
    .arb_advance  (arb_advance),
    .grant        (grant),
    .load_pending (load_pending)
  );

  vpa_port_model u_model (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .period_end  (period_end),
    .hold_off    (hold_off),
    .arb_advance (arb_advance)
  );

  // 20 MHz core clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // one-cycle register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // one-cycle read, data taken in the following cycle only
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
    #1 `CHK(rd_data, 32'h0000_0000)
  endtask

  // end one period through the model, then check the new grant
  task automatic step(input logic [3:0] p);
    @(posedge clk);
    period_end <= 1'b1;
    @(posedge clk);
    period_end <= 1'b0;
    repeat (hold_off ? 2 : 1) @(posedge clk);
    #1 `CHK({grant.valid, grant.port}, {1'b1, p})
  endtask

  // poll status until the table copy has finished
  task automatic wait_load();
    for (int i = 0; i < 20; i++) begin
      rd(vpa_pkg::OFS_STAT, v);
      if (v[vpa_pkg::PEND_BIT] === 1'b0) break;
    end
    `CHK(v, 32'h0000_0000)
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #(50 * 20000);
    err_count++;
    test_done();
  end

  initial begin
    sys_rst    = 1'b1;
    bus        = '0;
    period_end = 1'b0;
    hold_off   = 1'b0;
    err_count  = 0;
    n_checks   = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1 `CHK({grant.valid, grant.port}, 5'h10)
    `CHK(load_pending, 1'b0)
    rd(vpa_pkg::OFS_WORD0, v);
    `CHK(v, 32'h3322_1100)
    rd(vpa_pkg::OFS_WORD1, v);
    `CHK(v, 32'h7766_5544)
    rd(vpa_pkg::OFS_WORD2, v);
    `CHK(v, 32'hBBAA_9988)
    $display("test reset values done");

    // default schedule walk, codes 0..11, wrap after slot 23
    for (int i = 1; i < 24; i++) begin
      hold_off <= i[0];
      step(4'(i / 2));
    end
    hold_off <= 1'b0;
    step(4'h0);
    $display("test default walk done");

    // reserved codes in slots 1,3,4,5,6 and a short schedule
    wr(vpa_pkg::OFS_WORD0, 32'h5CDE_F1C0);
    #1 `CHK(load_pending, 1'b1)
    rd(vpa_pkg::OFS_WORD0, v);
    `CHK(v, 32'h5CDE_F1C0)
    wr(vpa_pkg::OFS_CTRL, 32'h0001_0008);
    rd(vpa_pkg::OFS_CTRL, v);
    `CHK(v, 32'h0000_0008)
    wait_load();
    #1 `CHK({grant.valid, grant.port}, 5'h10)
    step(4'h1);
    step(4'h5);
    step(4'h4);
    step(4'h0);
    $display("test skip and wrap done");

    // last-slot clamp, table write during a copy keeps pending
    wr(vpa_pkg::OFS_CTRL, 32'h0000_001F);
    rd(vpa_pkg::OFS_CTRL, v);
    `CHK(v, 32'h0000_0017)
    wr(vpa_pkg::OFS_CTRL, 32'h0001_0017);
    wr(vpa_pkg::OFS_WORD2, 32'h0000_0000);
    repeat (8) @(posedge clk);
    rd(vpa_pkg::OFS_STAT, v);
    `CHK(v, 32'h0001_0000)
    wr(vpa_pkg::OFS_CTRL, 32'h0000_0017);
    rd(vpa_pkg::OFS_STAT, v);
    `CHK(v, 32'h0001_0000)
    wr(vpa_pkg::OFS_CTRL, 32'h0001_0017);
    wait_load();
    step(4'h1);
    step(4'h5);
    for (int i = 8; i < 17; i++) begin
      step(i < 16 ? 4'(i / 2) : 4'h0);
    end
    $display("test pending done");

    // unmapped place reads zero and ignores writes
    wr(12'h23C, 32'hFFFF_FFFF);
    rd(12'h23C, v);
    `CHK(v, 32'h0000_0000)
    rd(vpa_pkg::OFS_WORD2, v);
    `CHK(v, 32'h0000_0000)
    $display("test unmapped done");

    // valid codes read back, then a schedule with no usable slot
    wr(vpa_pkg::OFS_WORD1, 32'h0123_4567);
    rd(vpa_pkg::OFS_WORD1, v);
    `CHK(v, 32'h0123_4567)
    wr(vpa_pkg::OFS_WORD0, 32'hFFFF_FFFF);
    wr(vpa_pkg::OFS_CTRL, 32'h0001_0001);
    wait_load();
    `CHK(grant.valid, 1'b0)
    $display("test no usable slot done");
    test_done();
  end
endmodule
